// ### include/pcpc_pkg.sv
package pcpc_pkg;
   localparam int unsigned width = 8;
   // register addresses on the plain port
   localparam logic [1:0] addr_pin_data = 2'h0;
   localparam logic [1:0] addr_output_latch = 2'h1;
   localparam logic [1:0] addr_direction = 2'h2;
   localparam logic [1:0] addr_pin_select = 2'h3;
   // reset values
   localparam logic [7:0] direction_reset = 8'hff;
   localparam logic [7:0] latch_reset = 8'h00;
   localparam logic capture_two_pin_select_erased = 1'h1;
   // pin positions
   localparam int unsigned pin_zero = 0;
   localparam int unsigned pin_one = 1;
   localparam int unsigned pin_two = 2;
   localparam int unsigned pin_three = 3;

   typedef struct packed {
      logic osc_enable;
      logic capture_two_enable;
      logic capture_two_out;
      logic capture_one_enable;
      logic capture_one_out;
      logic pwm_a_enable;
      logic pwm_a_out;
      logic pwm_a_shutdown_tristate;
      logic serial_clock_enable;
      logic serial_clock_out;
   } pcpc_periph_type;

   typedef struct packed {
      logic [7:0] value;
      logic [7:0] enable;
   } pcpc_drive_type;
endpackage

// ### verilog/pcpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pcpc_sync #(
   parameter int unsigned width = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // data
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] stage_one;
   logic [width-1:0] next_stage_one;
   logic [width-1:0] next_sync_out;

   initial begin
      if (width < 1) $error("width must be at least one");
   end

   always_comb begin
      next_stage_one = async_in;
      next_sync_out = stage_one;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= next_stage_one;
         sync_out <= next_sync_out;
      end
   end
endmodule
`default_nettype wire

// ### verilog/pcpc_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pcpc_pin_mux (
   // register state
   input wire logic [7:0] direction,
   input wire logic [7:0] output_latch,
   input wire logic capture_two_pin_select,
   // peripherals
   input wire pcpc_pkg::pcpc_periph_type periph,
   // pin drive
   output var pcpc_pkg::pcpc_drive_type drive,
   output logic [7:0] digital_enable
);
   always_comb begin
      drive.value = output_latch;
      drive.enable = ~direction;
      digital_enable = 8'hff;
      // oscillator owns pins zero and one
      if (periph.osc_enable) begin
         drive.enable[pcpc_pkg::pin_zero] = 1'b0;
         drive.enable[pcpc_pkg::pin_one] = 1'b0;
         digital_enable[pcpc_pkg::pin_zero] = 1'b0;
         digital_enable[pcpc_pkg::pin_one] = 1'b0;
      end else if (capture_two_pin_select && periph.capture_two_enable) begin
         drive.value[pcpc_pkg::pin_one] = periph.capture_two_out;
      end
      // enhanced channel beats plain capture unit
      if (periph.pwm_a_enable) begin
         drive.value[pcpc_pkg::pin_two] = periph.pwm_a_out;
         if (periph.pwm_a_shutdown_tristate) begin
            drive.enable[pcpc_pkg::pin_two] = 1'b0;
         end
      end else if (periph.capture_one_enable) begin
         drive.value[pcpc_pkg::pin_two] = periph.capture_one_out;
      end
      if (periph.serial_clock_enable) begin
         drive.value[pcpc_pkg::pin_three] = periph.serial_clock_out;
      end
   end
endmodule
`default_nettype wire

// ### verilog/pcpc_port.sv
// Function
// - the port has eight pins, each usable as digital input or output.
// - a direction bit of one turns the pin driver off and makes it an input.
// - a direction bit of zero drives the pin from its output latch bit.
// - the output latch is addressable and reads back latched values, not pins.
// - a configuration bit, erased to one, places capture unit two on pin one.
// - an enabled peripheral may override a pin direction bit.
// - after power-on reset every pin is a digital input.
// - reading the direction register returns stored bits despite overrides.
// - with the oscillator on, pin zero is its output and digital io is off.
// - with the oscillator on, pin one is its input and digital io is off.
// - capture unit two on pin one drives output at direction zero, captures at one.
// - capture unit one on pin two drives output at direction zero, captures at one.
// - enhanced pwm channel a beats port data on pin two and may tristate on shutdown.
// - the serial unit drives its spi clock on pin three at direction zero.
// - at direction one the serial unit takes its spi clock from pin three.
`timescale 1ns/1ps
`default_nettype none
module pcpc_port #(
   parameter logic capture_two_pin_select_default = pcpc_pkg::capture_two_pin_select_erased
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   // peripheral controls
   input wire pcpc_pkg::pcpc_periph_type periph,
   // peripheral inputs
   output logic osc_drive_active,
   output logic timer_counter_clock_input,
   output logic capture_two_in,
   output logic capture_one_in,
   output logic serial_clock_in,
   output logic capture_two_pin_select
);
   logic [7:0] direction;
   logic [7:0] output_latch;
   logic [7:0] pin_sync;
   logic [7:0] digital_enable;
   logic [7:0] next_direction;
   logic [7:0] next_output_latch;
   logic [7:0] next_rdata;
   logic next_select;
   logic [7:0] next_pin_out;
   logic [7:0] next_pin_oe;
   logic next_osc;
   logic [3:0] next_in;
   pcpc_pkg::pcpc_drive_type drive;

   pcpc_sync #(
      .width(pcpc_pkg::width)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   pcpc_pin_mux u_mux (
      .direction(direction),
      .output_latch(output_latch),
      .capture_two_pin_select(capture_two_pin_select),
      .periph(periph),
      .drive(drive),
      .digital_enable(digital_enable)
   );

   // register writes
   always_comb begin
      next_direction = direction;
      next_output_latch = output_latch;
      next_select = capture_two_pin_select;
      if (reg_write) begin
         case (reg_addr)
            pcpc_pkg::addr_pin_data: next_output_latch = reg_wdata;
            pcpc_pkg::addr_output_latch: next_output_latch = reg_wdata;
            pcpc_pkg::addr_direction: next_direction = reg_wdata;
            pcpc_pkg::addr_pin_select: next_select = reg_wdata[0];
            default: next_direction = direction;
         endcase
      end
   end

   // register reads, data one cycle later
   always_comb begin
      next_rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            pcpc_pkg::addr_pin_data: next_rdata = pin_sync & digital_enable;
            pcpc_pkg::addr_output_latch: next_rdata = output_latch;
            pcpc_pkg::addr_direction: next_rdata = direction;
            pcpc_pkg::addr_pin_select: next_rdata = {7'h00, capture_two_pin_select};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // registered pin drive and peripheral inputs
   always_comb begin
      next_pin_out = drive.value;
      next_pin_oe = drive.enable;
      next_osc = periph.osc_enable;
      next_in[0] = direction[pcpc_pkg::pin_zero] & digital_enable[pcpc_pkg::pin_zero]
         & pin_sync[pcpc_pkg::pin_zero];
      next_in[1] = capture_two_pin_select & direction[pcpc_pkg::pin_one]
         & digital_enable[pcpc_pkg::pin_one] & pin_sync[pcpc_pkg::pin_one];
      next_in[2] = direction[pcpc_pkg::pin_two] & pin_sync[pcpc_pkg::pin_two];
      next_in[3] = direction[pcpc_pkg::pin_three] & pin_sync[pcpc_pkg::pin_three];
   end

   // register state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         direction <= pcpc_pkg::direction_reset;
         output_latch <= pcpc_pkg::latch_reset;
         capture_two_pin_select <= capture_two_pin_select_default;
      end else begin
         direction <= next_direction;
         output_latch <= next_output_latch;
         capture_two_pin_select <= next_select;
      end
   end

   // read data
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // pin drive and peripheral inputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         osc_drive_active <= 1'b0;
         timer_counter_clock_input <= 1'b0;
         capture_two_in <= 1'b0;
         capture_one_in <= 1'b0;
         serial_clock_in <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         osc_drive_active <= next_osc;
         timer_counter_clock_input <= next_in[0];
         capture_two_in <= next_in[1];
         capture_one_in <= next_in[2];
         serial_clock_in <= next_in[3];
      end
   end

   initial begin
      if (capture_two_pin_select_default !== pcpc_pkg::capture_two_pin_select_erased
          && capture_two_pin_select_default !== 1'b0) $error("bad select default");
   end

   // strobe aimed at one register
   function automatic logic hits(input logic strobe, input logic [1:0] addr,
         input logic [1:0] target);
      return strobe && addr == target;
   endfunction

   // checks
   sequence dir_written_s;
      reg_write && reg_addr == pcpc_pkg::addr_direction;
   endsequence

   sequence dir_read_s;
      reg_read && reg_addr == pcpc_pkg::addr_direction;
   endsequence

   sequence latch_written_s;
      hits(reg_write, reg_addr, pcpc_pkg::addr_output_latch);
   endsequence

   sequence latch_read_s;
      hits(reg_read, reg_addr, pcpc_pkg::addr_output_latch);
   endsequence

   // pins four to seven follow the registers alone
   for (genvar p = 4; p < 8; p++) begin : plain_pin_g
      input_off_a: assert property (@(posedge clk) disable iff (reset)
         direction[p] |=> !pin_oe[p])
         else $error("input pin driven");

      latch_drive_a: assert property (@(posedge clk) disable iff (reset)
         !direction[p] |=> pin_oe[p] && pin_out[p] == $past(output_latch[p]))
         else $error("output pin not from latch");
   end

   reset_state_a: assert property (@(posedge clk)
      reset ##1 reset |-> pin_oe == 8'h00 && direction == pcpc_pkg::direction_reset)
      else $error("pins not inputs in reset");

   latch_readback_a: assert property (@(posedge clk) disable iff (reset)
      (reg_read && reg_addr == pcpc_pkg::addr_output_latch) |=> reg_rdata == $past(output_latch))
      else $error("latch readback wrong");

   latch_write_a: assert property (@(posedge clk) disable iff (reset)
      hits(reg_write, reg_addr, pcpc_pkg::addr_output_latch)
      |=> output_latch == $past(reg_wdata))
      else $error("latch write lost");

   latch_back_a: assert property (@(posedge clk) disable iff (reset)
      latch_written_s ##1 latch_read_s |=> reg_rdata == $past(reg_wdata, 2))
      else $error("latch write then read wrong");

   data_write_a: assert property (@(posedge clk) disable iff (reset)
      hits(reg_write, reg_addr, pcpc_pkg::addr_pin_data)
      |=> output_latch == $past(reg_wdata))
      else $error("pin data write lost");

   dir_write_a: assert property (@(posedge clk) disable iff (reset)
      dir_written_s |=> direction == $past(reg_wdata))
      else $error("direction write lost");

   dir_readback_a: assert property (@(posedge clk) disable iff (reset)
      dir_written_s ##1 dir_read_s |=> reg_rdata == $past(reg_wdata, 2))
      else $error("direction readback wrong");

   select_read_a: assert property (@(posedge clk) disable iff (reset)
      hits(reg_read, reg_addr, pcpc_pkg::addr_pin_select)
      |=> reg_rdata == {7'h00, $past(capture_two_pin_select)})
      else $error("select readback wrong");

   osc_pins_a: assert property (@(posedge clk) disable iff (reset)
      periph.osc_enable |=> pin_oe[1:0] == 2'h0 && osc_drive_active)
      else $error("oscillator pins driven");

   osc_inputs_off_a: assert property (@(posedge clk) disable iff (reset)
      periph.osc_enable |=> !capture_two_in && !timer_counter_clock_input)
      else $error("oscillator pins still read");

   osc_read_a: assert property (@(posedge clk) disable iff (reset)
      hits(reg_read, reg_addr, pcpc_pkg::addr_pin_data) && periph.osc_enable
      |=> reg_rdata[1:0] == 2'h0)
      else $error("oscillator pins read as data");

   pwm_a_pin_a: assert property (@(posedge clk) disable iff (reset)
      (periph.pwm_a_enable && !direction[2] && !periph.pwm_a_shutdown_tristate)
      |=> pin_out[2] == $past(periph.pwm_a_out))
      else $error("pwm channel a not on pin two");

   pwm_tristate_a: assert property (@(posedge clk) disable iff (reset)
      periph.pwm_a_enable && periph.pwm_a_shutdown_tristate |=> !pin_oe[2])
      else $error("pin two driven in shutdown");

   capture_one_a: assert property (@(posedge clk) disable iff (reset)
      periph.capture_one_enable && !periph.pwm_a_enable && !direction[2]
      |=> pin_oe[2] && pin_out[2] == $past(periph.capture_one_out))
      else $error("capture one output missing");

   capture_one_in_a: assert property (@(posedge clk) disable iff (reset)
      direction[2] |=> capture_one_in == $past(pin_sync[2]))
      else $error("capture one input wrong");

   spi_clock_a: assert property (@(posedge clk) disable iff (reset)
      (periph.serial_clock_enable && !direction[3])
      |=> pin_out[3] == $past(periph.serial_clock_out))
      else $error("spi clock not on pin three");

   spi_drive_a: assert property (@(posedge clk) disable iff (reset)
      periph.serial_clock_enable && !direction[3] |=> pin_oe[3])
      else $error("spi clock pin not driven");

   spi_in_a: assert property (@(posedge clk) disable iff (reset)
      direction[3] |=> serial_clock_in == $past(pin_sync[3]))
      else $error("spi clock input wrong");

   timer_in_a: assert property (@(posedge clk) disable iff (reset)
      direction[0] && !periph.osc_enable
      |=> timer_counter_clock_input == $past(pin_sync[0]))
      else $error("timer input wrong");

   pin_read_a: assert property (@(posedge clk) disable iff (reset)
      (reg_read && reg_addr == pcpc_pkg::addr_pin_data && !periph.osc_enable)
      |=> reg_rdata == $past(pin_sync))
      else $error("pin data read wrong");

   capture_two_a: assert property (@(posedge clk) disable iff (reset)
      (periph.capture_two_enable && !periph.osc_enable && capture_two_pin_select && !direction[1])
      |=> pin_out[1] == $past(periph.capture_two_out))
      else $error("capture two output missing");

   capture_two_in_a: assert property (@(posedge clk) disable iff (reset)
      capture_two_pin_select && direction[1] && !periph.osc_enable
      |=> capture_two_in == $past(pin_sync[1]))
      else $error("capture two input wrong");

   unselected_two_a: assert property (@(posedge clk) disable iff (reset)
      !capture_two_pin_select && !periph.osc_enable && !direction[1]
      |=> pin_out[1] == $past(output_latch[1]))
      else $error("pin one not from latch");
endmodule
`default_nettype wire

// ### bench/pcpc_board.sv
`timescale 1ns/1ps
`default_nettype none
module pcpc_board (
   // clock
   input wire logic clk,
   // device pins
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   output logic [7:0] pin_in,
   // board drivers
   input wire logic [7:0] ext_drive,
   input wire logic [7:0] ext_level
);
   logic [7:0] float_pattern = 8'h55;
   // undriven pins wander every cycle
   always @(posedge clk) begin
      float_pattern <= ~float_pattern;
   end
   // board drives only pins the device leaves free
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_drive[i] ? ext_level[i] : float_pattern[i]);
      end
   end
endmodule
`default_nettype wire

// ### bench/port_c_pin_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define chk(name, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", name, exp, got); end end
module port_c_pin_control_tb;
   logic clk = 0;
   logic reset = 1;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 0;
   logic reg_read = 0;
   logic [7:0] reg_rdata, pin_in, pin_out, pin_oe;
   logic [7:0] ext_drive = 8'h00;
   logic [7:0] ext_level = 8'h00;
   pcpc_pkg::pcpc_periph_type periph = '0;
   logic osc_drive_active, timer_in, cap_two_in, cap_one_in, ser_clk_in, pin_select;
   int n_mismatch = 0;
   int checked = 0;
   logic [7:0] rv;
   always #20 clk = ~clk;
   pcpc_port dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .periph(periph), .osc_drive_active(osc_drive_active),
      .timer_counter_clock_input(timer_in), .capture_two_in(cap_two_in),
      .capture_one_in(cap_one_in), .serial_clock_in(ser_clk_in),
      .capture_two_pin_select(pin_select));
   pcpc_board board_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
      .ext_drive(ext_drive), .ext_level(ext_level));
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1;
      @(posedge clk);
      reg_write <= 0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1;
      @(posedge clk);
      reg_read <= 0;
      #1 rv = reg_rdata;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_rd(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1;
      @(posedge clk);
      reg_write <= 0;
      reg_read <= 1;
      @(posedge clk);
      reg_read <= 0;
      #1 rv = reg_rdata;
   endtask
   task automatic t_back;
      wr_rd(pcpc_pkg::addr_direction, 8'h3c);
      `chk("direction", 8'h3c, rv)
      wr_rd(pcpc_pkg::addr_output_latch, 8'hc3);
      `chk("latch", 8'hc3, rv)
   endtask
   task automatic t_reset;
      rd(pcpc_pkg::addr_direction);
      `chk("direction", pcpc_pkg::direction_reset, rv)
      rd(pcpc_pkg::addr_output_latch);
      `chk("latch", pcpc_pkg::latch_reset, rv)
      `chk("pin_oe", 8'h00, pin_oe)
      `chk("select", 1'h1, pin_select)
   endtask
   task automatic t_output;
      wr(pcpc_pkg::addr_output_latch, 8'ha5);
      wr(pcpc_pkg::addr_direction, 8'h00);
      settle(3);
      `chk("pin_oe", 8'hff, pin_oe)
      `chk("pin_out", 8'ha5, pin_out)
      wr(pcpc_pkg::addr_direction, 8'hf0);
      settle(3);
      `chk("pin_oe", 8'h0f, pin_oe)
      rd(pcpc_pkg::addr_output_latch);
      `chk("latch", 8'ha5, rv)
   endtask
   task automatic t_pins;
      wr(pcpc_pkg::addr_direction, 8'hff);
      ext_drive <= 8'hff;
      ext_level <= 8'h0d;
      settle(5);
      rd(pcpc_pkg::addr_pin_data);
      `chk("pin data", 8'h0d, rv)
      `chk("timer in", 1'h1, timer_in)
      `chk("capture two in", 1'h0, cap_two_in)
      `chk("capture one in", 1'h1, cap_one_in)
      `chk("serial clock in", 1'h1, ser_clk_in)
      @(posedge clk);
      ext_level <= 8'h32;
      settle(5);
      rd(pcpc_pkg::addr_pin_data);
      `chk("pin data", 8'h32, rv)
      `chk("timer in", 1'h0, timer_in)
      `chk("capture two in", 1'h1, cap_two_in)
      `chk("capture one in", 1'h0, cap_one_in)
      `chk("serial clock in", 1'h0, ser_clk_in)
      wr(pcpc_pkg::addr_pin_data, 8'h5a);
      rd(pcpc_pkg::addr_output_latch);
      `chk("latch", 8'h5a, rv)
      @(posedge clk);
      ext_drive <= 8'h00;
   endtask
   task automatic t_periph;
      wr(pcpc_pkg::addr_output_latch, 8'h00);
      wr(pcpc_pkg::addr_direction, 8'h00);
      periph.capture_two_enable <= 1;
      periph.capture_two_out <= 1;
      periph.capture_one_enable <= 1;
      periph.capture_one_out <= 1;
      periph.serial_clock_enable <= 1;
      periph.serial_clock_out <= 1;
      settle(3);
      `chk("pin one", 1'h1, pin_out[1])
      `chk("pin two", 1'h1, pin_out[2])
      `chk("pin three", 1'h1, pin_out[3])
      @(posedge clk);
      periph.pwm_a_enable <= 1;
      periph.pwm_a_out <= 0;
      settle(3);
      `chk("pin two", 1'h0, pin_out[2])
      @(posedge clk);
      periph.pwm_a_shutdown_tristate <= 1;
      settle(3);
      `chk("pin two oe", 1'h0, pin_oe[2])
      @(posedge clk);
      periph.osc_enable <= 1;
      settle(3);
      `chk("osc active", 1'h1, osc_drive_active)
      `chk("pin zero oe", 1'h0, pin_oe[0])
      `chk("pin one oe", 1'h0, pin_oe[1])
      rd(pcpc_pkg::addr_direction);
      `chk("direction", 8'h00, rv)
      rd(pcpc_pkg::addr_pin_data);
      `chk("osc pin data", 2'h0, rv[1:0])
      @(posedge clk);
      periph.osc_enable <= 0;
      wr(pcpc_pkg::addr_pin_select, 8'h00);
      settle(3);
      `chk("select", 1'h0, pin_select)
      `chk("pin one", 1'h0, pin_out[1])
      rd(pcpc_pkg::addr_pin_select);
      `chk("select reg", 8'h00, rv)
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset <= 0;
      t_reset();
      t_output();
      t_back();
      t_pins();
      t_periph();
      tally_and_finish();
   end
endmodule
`default_nettype wire
